// [lrc_actuator_model.sv]
// Behavioural actuator: back-EMF zero crossings at a fixed half period
`timescale 1ns/100ps
module lrc_actuator_model #(
    parameter int HALF_CYC = 12195
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic moving_in,
    output logic zero_cross_out
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic zc_d;
    // At rest the comparator holds its level: no crossings at all
    always_comb begin
        cnt_d = moving_in ? cnt_q + 16'h0001 : 16'h0000;
        zc_d = zero_cross_out;
        if (cnt_q == 16'(HALF_CYC - 1)) begin
            cnt_d = 16'h0000;
            zc_d = !zero_cross_out;
        end
    end
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= 16'h0000;
            zero_cross_out <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            zero_cross_out <= zc_d;
        end
    end
endmodule // lrc_actuator_model

// [lrc_params.svh]
// Constants for the resonance loop controller: offsets, fields, resets, timing
// How it works
// R1 - Actuator outputs are pulse-width modulated on a 20.5 kHz carrier.
// R2 - Output waveform starts within 1 ms of a trigger.
// R3 - Software selects ERM or LRA before starting a waveform.
// R4 - LRA tracker locks to resonance within half a drive cycle.
// R5 - Tracker follows back-EMF continuously, updating frequency every cycle.
// R6 - Tracker needs no calibration; level calibration never affects it.
// R7 - Tracked resonance period is readable by software, updated live.
// R8 - Software reads the resonance only while synchronized, not idle or braking.
// R9 - Invalid LRA back-EMF falls back to open-loop overdrive at drive-time rate.
// R10 - Valid back-EMF during fallback hands control back to the tracker.
// R11 - With auto fallback enabled, open loop is kept for the rest of the waveform.
// R12 - Permanent open loop is entered only after failing to synchronize.
// R13 - Two-bit limit sets tolerated unsynchronized cycles before open loop; the count saturates at 3, so limit 3 never enters open loop.
// R14 - Open-loop LRA period is the seven-bit field times 97.56 us.
// R15 - Open loop applies no automatic overdrive or braking; the code drives fallback at full scale (8'hFF).
// R16 - Closed loop applies startup overdrive and active braking for both actuators.
// R17 - Loop state is tracking, fallback or fixed open loop; each waveform restarts tracking.
`ifndef LRC_PARAMS_SVH
`define LRC_PARAMS_SVH

// ***************************************************************
// Register offsets (byte addresses)
// ***************************************************************
`define LRC_OFS_CTRL 8'h00
`define LRC_OFS_CFG 8'h04
`define LRC_OFS_AMP 8'h08
`define LRC_OFS_STATUS 8'h0C
`define LRC_OFS_FREQ 8'h10

// ***************************************************************
// Field positions
// ***************************************************************
`define LRC_CTRL_TYPE_BIT 0
`define LRC_CTRL_AUTOFB_BIT 1
`define LRC_CTRL_GO_BIT 2
`define LRC_CTRL_STOP_BIT 3
`define LRC_CFG_LIMIT_LSB 0
`define LRC_CFG_PERIOD_LSB 8
`define LRC_CFG_DRIVE_LSB 16
`define LRC_CFG_ZCDET_LSB 24

// ***************************************************************
// Reset values
// ***************************************************************
`define LRC_CTRL_RST 2'h0
`define LRC_LIMIT_RST 2'h1
`define LRC_PERIOD_RST 7'h32
`define LRC_DRIVE_RST 5'h0D
`define LRC_ZCDET_RST 2'h1
`define LRC_AMP_RST 8'h80
`define LRC_HALF_RST 16'h003C

// ***************************************************************
// Timing
// ***************************************************************
`define LRC_CLK_PERIOD_NS 20
`define LRC_PWM_FREQ_HZ 20500
`define LRC_PWM_PERIOD_NS (1000000000 / `LRC_PWM_FREQ_HZ)
`define LRC_PWM_CYCLES (`LRC_PWM_PERIOD_NS / `LRC_CLK_PERIOD_NS)
`define LRC_OL_UNIT_NS 97560
`define LRC_OL_UNIT_TICKS (`LRC_OL_UNIT_NS / `LRC_PWM_PERIOD_NS)
`define LRC_START_MAX_NS 1000000
`define LRC_START_MAX_TICKS (`LRC_START_MAX_NS / `LRC_PWM_PERIOD_NS)
`define LRC_OD_TICKS 16'h0028
`define LRC_BRAKE_TICKS 16'h0028

`endif

// [lrc_pkg.sv]
// Types shared by the resonance loop controller modules
package lrc_pkg;

    // Loop states, one-hot
    typedef enum logic [4:0] {
        LRC_ST_IDLE = 5'b00001,
        LRC_ST_TRACK = 5'b00010,
        LRC_ST_FALLBACK = 5'b00100,
        LRC_ST_FIXED = 5'b01000,
        LRC_ST_BRAKE = 5'b10000
    } lrc_state_t;

    typedef struct packed {
        logic lra;
        logic auto_fb;
        logic [1:0] unsync_cycle_limit;
        logic [6:0] fixed_drive_period;
        logic [4:0] drive_time;
        logic [1:0] zero_cross_detect_time;
        logic [7:0] amp;
    } lrc_cfg_t;

    typedef struct packed {
        logic en;
        logic pol;
        logic [7:0] amp;
    } lrc_drive_t;

endpackage

// [lrc_pwm.sv]
// Differential PWM carrier generator for the actuator outputs
`timescale 1ns/100ps
`include "lrc_params.svh"
module lrc_pwm #(
    parameter int CYCLES = `LRC_PWM_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input lrc_pkg::lrc_drive_t drive_in,
    output logic tick_out,
    output logic out_p_out,
    output logic out_n_out
);
    import lrc_pkg::*;

    logic [11:0] cnt_q, cnt_d;
    logic tick_q, tick_d;
    logic out_p_q, out_p_d;
    logic out_n_q, out_n_d;
    logic [19:0] thresh;

    always_comb begin
        thresh = ({12'h000, drive_in.amp} * CYCLES[19:0]) >> 8;
        tick_d = 1'b0;
        if (cnt_q == 12'(CYCLES - 1)) begin
            cnt_d = 12'h000;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 12'h001;
        end
        // High side pulses, other side held low; idle leaves both low
        out_p_d = drive_in.en && !drive_in.pol && ({8'h00, cnt_q} < thresh); // [R1]
        out_n_d = drive_in.en && drive_in.pol && ({8'h00, cnt_q} < thresh); // [R1]
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= 12'h000;
            tick_q <= 1'b0;
            out_p_q <= 1'b0;
            out_n_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
            out_p_q <= out_p_d;
            out_n_q <= out_n_d;
        end
    end

    assign tick_out = tick_q;
    assign out_p_out = out_p_q;
    assign out_n_out = out_n_q;

endmodule // lrc_pwm

// [lrc_top.sv]
// Resonance loop controller: Wishbone registers, back-EMF tracking, loop state, drive
`timescale 1ns/100ps
`include "lrc_params.svh"
module lrc_top (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic trig_in,
    input wire logic bemf_zero_cross_in,
    input wire logic bemf_valid_in,
    output logic out_p_out,
    output logic out_n_out
);
    import lrc_pkg::*;

    // ***************************************************************
    // Helpers
    // ***************************************************************
    function automatic logic [31:0] wb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] at_least_one(input logic [15:0] v);
        return ((v == 16'h0000) || v[15]) ? 16'h0001 : v;
    endfunction

    // ***************************************************************
    // Pin synchronisers
    // ***************************************************************
    logic [2:0] trig_s_q, zc_s_q, val_s_q;
    logic trig_f_q, trig_f_d;
    logic zc_f_q, zc_f_d;
    logic val_f_q, val_f_d;

    always_comb begin
        // A change counts once stages two and three agree
        trig_f_d = (trig_s_q[1] == trig_s_q[2]) ? trig_s_q[2] : trig_f_q;
        zc_f_d = (zc_s_q[1] == zc_s_q[2]) ? zc_s_q[2] : zc_f_q;
        val_f_d = (val_s_q[1] == val_s_q[2]) ? val_s_q[2] : val_f_q;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            trig_s_q <= 3'h0;
            zc_s_q <= 3'h0;
            val_s_q <= 3'h0;
            trig_f_q <= 1'b0;
            zc_f_q <= 1'b0;
            val_f_q <= 1'b0;
        end else begin
            trig_s_q <= {trig_s_q[1:0], trig_in};
            zc_s_q <= {zc_s_q[1:0], bemf_zero_cross_in};
            val_s_q <= {val_s_q[1:0], bemf_valid_in};
            trig_f_q <= trig_f_d;
            zc_f_q <= zc_f_d;
            val_f_q <= val_f_d;
        end
    end

    logic trig_rise;
    logic zc_evt;
    logic trig_prev_q, zc_prev_q;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            trig_prev_q <= 1'b0;
            zc_prev_q <= 1'b0;
        end else begin
            trig_prev_q <= trig_f_q;
            zc_prev_q <= zc_f_q;
        end
    end
    assign trig_rise = trig_f_q && !trig_prev_q;
    // Either polarity of the comparator marks a zero crossing
    assign zc_evt = zc_f_q != zc_prev_q;

    // ***************************************************************
    // Wishbone register file
    // ***************************************************************
    lrc_cfg_t cfg_q, cfg_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic go_q, go_d;
    logic stop_q, stop_d;
    lrc_state_t st_q, st_d;
    logic [15:0] freq_q, freq_d;
    logic [1:0] unsync_q, unsync_d;
    logic synced;
    logic [31:0] ctrl_rd, cfg_rd, wr_v;
    logic access;

    always_comb begin
        cfg_d = cfg_q;
        go_d = 1'b0;
        stop_d = 1'b0;
        access = wb_cyc_in && wb_stb_in && !ack_q;
        ack_d = access;
        ctrl_rd = {30'h0000_0000, cfg_q.auto_fb, cfg_q.lra};
        cfg_rd = {6'h00, cfg_q.zero_cross_detect_time, 3'h0, cfg_q.drive_time,
                  1'b0, cfg_q.fixed_drive_period, 6'h00, cfg_q.unsync_cycle_limit};
        rdat_d = 32'h0000_0000;
        wr_v = 32'h0000_0000;
        if (access && wb_we_in) begin
            if (wb_adr_in == `LRC_OFS_CTRL) begin
                wr_v = wb_merge(ctrl_rd, wb_dat_in, wb_sel_in);
                cfg_d.lra = wr_v[`LRC_CTRL_TYPE_BIT]; // [R3]
                cfg_d.auto_fb = wr_v[`LRC_CTRL_AUTOFB_BIT];
                go_d = wb_sel_in[0] && wb_dat_in[`LRC_CTRL_GO_BIT];
                stop_d = wb_sel_in[0] && wb_dat_in[`LRC_CTRL_STOP_BIT];
            end else if (wb_adr_in == `LRC_OFS_CFG) begin
                wr_v = wb_merge(cfg_rd, wb_dat_in, wb_sel_in);
                cfg_d.unsync_cycle_limit = wr_v[`LRC_CFG_LIMIT_LSB +: 2];
                cfg_d.fixed_drive_period = wr_v[`LRC_CFG_PERIOD_LSB +: 7];
                cfg_d.drive_time = wr_v[`LRC_CFG_DRIVE_LSB +: 5];
                cfg_d.zero_cross_detect_time = wr_v[`LRC_CFG_ZCDET_LSB +: 2];
            end else if (wb_adr_in == `LRC_OFS_AMP) begin
                if (wb_sel_in[0]) begin
                    cfg_d.amp = wb_dat_in[7:0];
                end
            end
        end else if (access) begin
            if (wb_adr_in == `LRC_OFS_CTRL) begin
                rdat_d = ctrl_rd;
            end else if (wb_adr_in == `LRC_OFS_CFG) begin
                rdat_d = cfg_rd;
            end else if (wb_adr_in == `LRC_OFS_AMP) begin
                rdat_d = {24'h00_0000, cfg_q.amp};
            end else if (wb_adr_in == `LRC_OFS_STATUS) begin
                rdat_d = {24'h00_0000, synced, unsync_q, st_q};
            end else if (wb_adr_in == `LRC_OFS_FREQ) begin
                // Meaningful only while synced; idle or braking shows the last lock
                rdat_d = {16'h0000, freq_q}; // [R7] [R8]
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_q <= {`LRC_CTRL_RST, `LRC_LIMIT_RST, `LRC_PERIOD_RST, `LRC_DRIVE_RST,
                      `LRC_ZCDET_RST, `LRC_AMP_RST};
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            go_q <= 1'b0;
            stop_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            go_q <= go_d;
            stop_q <= stop_d;
        end
    end

    assign wb_ack_out = ack_q;
    assign wb_dat_out = rdat_q;

    // ***************************************************************
    // Loop state machine and resonance tracker
    // ***************************************************************
    logic tick;
    logic [15:0] phase_q, phase_d;
    logic [15:0] half_q, half_d;
    logic [15:0] od_q, od_d;
    logic [15:0] brk_q, brk_d;
    logic pol_q, pol_d;
    logic locked_q, locked_d;
    logic start;
    logic [15:0] fb_half, fixed_half;
    lrc_drive_t drv_q, drv_d;

    assign synced = (st_q == LRC_ST_TRACK) && cfg_q.lra && locked_q && (unsync_q == 2'h0);

    always_comb begin
        st_d = st_q;
        phase_d = phase_q;
        half_d = half_q;
        freq_d = freq_q;
        unsync_d = unsync_q;
        od_d = od_q;
        brk_d = brk_q;
        pol_d = pol_q;
        locked_d = locked_q;
        start = go_q || trig_rise;
        // Half period of the no-back-EMF drive: drive time less detect time
        fb_half = at_least_one(16'({11'h000, cfg_q.drive_time} -
                                   {14'h0000, cfg_q.zero_cross_detect_time})); // [R9]
        // Period = field x 97.56 us, so half of it is field x unit / 2
        fixed_half = at_least_one(16'(({9'h000, cfg_q.fixed_drive_period} *
                                       16'(`LRC_OL_UNIT_TICKS)) >> 1)); // [R14]
        case (st_q)
            LRC_ST_IDLE: begin
                if (start) begin
                    // Every waveform restarts in tracking with overdrive armed
                    st_d = LRC_ST_TRACK; // [R17] [R2]
                    phase_d = 16'h0000;
                    unsync_d = 2'h0;
                    locked_d = 1'b0;
                    pol_d = 1'b0;
                    od_d = `LRC_OD_TICKS; // [R16]
                end
            end
            LRC_ST_TRACK: begin
                if (tick && (od_q != 16'h0000)) begin
                    od_d = od_q - 16'h0001;
                end
                if (stop_q) begin
                    st_d = LRC_ST_BRAKE; // [R16]
                    brk_d = `LRC_BRAKE_TICKS;
                    pol_d = !pol_q;
                end else if (cfg_q.lra) begin
                    if (zc_evt) begin
                        // Flip at the crossing itself: lock within half a cycle
                        pol_d = !pol_q; // [R4]
                        half_d = at_least_one(phase_q); // [R5]
                        freq_d = 16'({at_least_one(phase_q), 1'b0}); // [R7]
                        phase_d = 16'h0000;
                        unsync_d = 2'h0;
                        locked_d = 1'b1;
                    end else if (tick) begin
                        phase_d = phase_q + 16'h0001;
                        if (phase_q >= 16'({half_q, 1'b0})) begin
                            // No crossing where one was due: an unsynced cycle
                            phase_d = 16'h0000;
                            pol_d = !pol_q;
                            if (unsync_q != 2'h3) begin
                                unsync_d = unsync_q + 2'h1; // [R13]
                            end
                        end
                    end
                    if (!val_f_q) begin
                        st_d = LRC_ST_FALLBACK; // [R9]
                        phase_d = 16'h0000;
                    end else if (cfg_q.auto_fb && (unsync_q > cfg_q.unsync_cycle_limit)) begin
                        st_d = LRC_ST_FIXED; // [R11] [R12] [R13]
                        phase_d = 16'h0000;
                    end
                end
            end
            LRC_ST_FALLBACK: begin
                if (stop_q) begin
                    st_d = LRC_ST_IDLE; // [R15]
                end else if (val_f_q) begin
                    st_d = LRC_ST_TRACK; // [R10]
                    phase_d = 16'h0000;
                end else if (tick) begin
                    phase_d = phase_q + 16'h0001;
                    if (phase_d >= fb_half) begin
                        phase_d = 16'h0000;
                        pol_d = !pol_q; // [R9]
                    end
                end
            end
            LRC_ST_FIXED: begin
                // Held until the waveform ends, no resynchronising
                if (stop_q) begin
                    st_d = LRC_ST_IDLE; // [R11] [R15]
                end else if (tick) begin
                    phase_d = phase_q + 16'h0001;
                    if (phase_d >= fixed_half) begin
                        phase_d = 16'h0000;
                        pol_d = !pol_q; // [R14]
                    end
                end
            end
            LRC_ST_BRAKE: begin
                // An LRA brake ends early once the actuator shows no back-EMF; an ERM brake runs its full count
                if (tick) begin
                    brk_d = brk_q - 16'h0001;
                end
                if ((tick && (brk_q == 16'h0001)) || (cfg_q.lra && !val_f_q)) begin
                    st_d = LRC_ST_IDLE;
                end
            end
            default: begin
                st_d = LRC_ST_IDLE;
            end
        endcase

        // Drive level: full scale during startup boost, brake and fallback; otherwise the programmed amplitude
        drv_d.en = st_q != LRC_ST_IDLE;
        drv_d.pol = cfg_q.lra ? pol_q : (st_q == LRC_ST_BRAKE);
        drv_d.amp = cfg_q.amp;
        if (st_q == LRC_ST_BRAKE) begin
            drv_d.amp = 8'hFF; // [R16]
        end else if ((st_q == LRC_ST_TRACK) && (od_q != 16'h0000)) begin
            drv_d.amp = 8'hFF; // [R16]
        end else if (st_q == LRC_ST_FALLBACK) begin
            drv_d.amp = 8'hFF; // [R9]
        end
    end

    // No calibration input exists; tracking depends only on back-EMF crossings [R6]
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= LRC_ST_IDLE;
            phase_q <= 16'h0000;
            half_q <= `LRC_HALF_RST;
            freq_q <= 16'h0000;
            unsync_q <= 2'h0;
            od_q <= 16'h0000;
            brk_q <= 16'h0000;
            pol_q <= 1'b0;
            locked_q <= 1'b0;
            drv_q <= '0;
        end else begin
            st_q <= st_d;
            phase_q <= phase_d;
            half_q <= half_d;
            freq_q <= freq_d;
            unsync_q <= unsync_d;
            od_q <= od_d;
            brk_q <= brk_d;
            pol_q <= pol_d;
            locked_q <= locked_d;
            drv_q <= drv_d;
        end
    end

    // ***************************************************************
    // Output stage
    // ***************************************************************
    // Drive reaches the pins within one carrier period, far inside the start limit
    lrc_pwm #(
        .CYCLES(`LRC_PWM_CYCLES)
    ) u_pwm (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .drive_in(drv_q),
        .tick_out(tick),
        .out_p_out(out_p_out),
        .out_n_out(out_n_out)
    ); // [R1] [R2]

endmodule // lrc_top

// [lrc_top_assertions.sv]
// Port-level assertions for the resonance loop controller
`timescale 1ns/100ps
module lrc_top_assertions (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic trig_in,
    input wire logic out_p_out,
    input wire logic out_n_out
);
    // Carrier length in clocks; start limit is 1 ms of clocks
    localparam int PWM_CYC = 2439;
    localparam int START_MAX = 50000;
    logic [15:0] hi_q;
    logic [15:0] hi_d;
    logic [16:0] wait_q;
    logic [16:0] wait_d;
    logic trig_q;
    always_comb begin
        hi_d = out_p_out ? hi_q + 16'h0001 : 16'h0000;
        wait_d = wait_q;
        if (out_p_out || out_n_out) begin
            wait_d = 17'h0_0000;
        end else if ((trig_in && !trig_q) || wait_q != 17'h0_0000) begin
            wait_d = wait_q + 17'h0_0001;
        end
    end
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hi_q <= 16'h0000;
            wait_q <= 17'h0_0000;
            trig_q <= 1'b0;
        end else begin
            hi_q <= hi_d;
            wait_q <= wait_d;
            trig_q <= trig_in;
        end
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    ack_one_cycle_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("no ack one cycle after request");
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
        else $error("ack without request");
    rdata_idle_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0000_0000)
        else $error("read data outside ack");
    sides_excl_a: assert property (!(out_p_out && out_n_out))
        else $error("both outputs high");
    pwm_carrier_a: assert property (hi_q < PWM_CYC)
        else $error("output high for a whole carrier period");
    start_time_a: assert property (wait_q <= START_MAX)
        else $error("no output within 1 ms of trigger");
    reset_quiet_a: assert property ($rose(rst_n_in) |-> !wb_ack_out && !out_p_out && !out_n_out)
        else $error("outputs active after reset release");
endmodule // lrc_top_assertions

bind lrc_top lrc_top_assertions i_lrc_top_assertions (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in),
    .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out),
    .trig_in(trig_in),
    .out_p_out(out_p_out),
    .out_n_out(out_n_out)
);

// [lrc_top_tb.sv]
// Self-checking bench for the resonance loop controller
`timescale 1ns/100ps
module lrc_top_tb;
    logic clk, rst_n, cyc, stb, we, ack, trig, zc, valid, moving, out_p, out_n;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    int n_fail;
    int cmp_count;
    lrc_top i_lrc_top (.sys_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .trig_in(trig), .bemf_zero_cross_in(zc), .bemf_valid_in(valid),
        .out_p_out(out_p), .out_n_out(out_n));
    lrc_actuator_model #(.HALF_CYC(12195)) i_lrc_actuator_model (.sys_clk_in(clk),
        .rst_n_in(rst_n), .moving_in(moving), .zero_cross_out(zc));
    always #10 clk = ~clk;
    // ***************************************************************
    // Shared tasks
    // ***************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        int i;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        if (i == 50) begin
            n_fail++;
            stop_test();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 4'hF, 32'h0000_0000);
    endtask
    task automatic wait_side(input logic side, input int bound, output int n);
        for (n = 0; n < bound; n++) begin
            @(negedge clk);
            if ((side ? out_n : out_p) === 1'b1) break;
        end
        if (n == bound) begin
            n_fail++;
            stop_test();
        end
    endtask
    // Polls the state register; a poll that never matches ends the run
    task automatic poll(input logic [7:0] want, input logic [7:0] mask);
        int i;
        for (i = 0; i < 400; i++) begin
            rd(8'h0C);
            if ((q[7:0] & mask) === want) break;
            repeat (250) @(posedge clk);
        end
        check("state", q & {24'h00_0000, mask}, {24'h00_0000, want});
        if (i == 400) stop_test();
    endtask
    // ***************************************************************
    // Scenarios
    // ***************************************************************
    task automatic reset_values();
        logic [7:0] a_t [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
        logic [31:0] e_t [6] = '{32'h0000_0000, 32'h010D_3201, 32'h0000_0080, 32'h0000_0001,
            32'h0000_0000, 32'h0000_0000};
        wb(1'b1, 8'h0C, 4'hF, 32'hFFFF_FFFF);
        wb(1'b1, 8'h10, 4'hF, 32'hFFFF_FFFF);
        wb(1'b1, 8'h20, 4'hF, 32'hFFFF_FFFF);
        for (int i = 0; i < 6; i++) begin
            rd(a_t[i]);
            check("reset value", q, e_t[i]);
        end
    endtask
    task automatic erm_start_stop();
        int n;
        wb(1'b1, 8'h00, 4'hF, 32'h0000_0000);
        @(posedge clk);
        trig <= 1'b1;
        repeat (8) @(posedge clk);
        trig <= 1'b0;
        wait_side(1'b0, 2600, n);
        rd(8'h0C);
        check("erm state", q & 32'h0000_001F, 32'h0000_0002);
        wb(1'b1, 8'h00, 4'hF, 32'h0000_0008);
        rd(8'h0C);
        check("erm brake", q & 32'h0000_001F, 32'h0000_0010);
        wait_side(1'b1, 2600, n);
        check("brake side", {31'h0000_0000, out_p}, 32'h0000_0000);
    endtask
    task automatic lra_track();
        wb(1'b1, 8'h04, 4'h3, 32'hFFFF_0200);
        rd(8'h04);
        check("byte enables", q, 32'h010D_0200);
        @(posedge clk);
        valid <= 1'b1;
        moving <= 1'b1;
        wb(1'b1, 8'h00, 4'hF, 32'h0000_0001);
        wb(1'b1, 8'h00, 4'hF, 32'h0000_0005);
        poll(8'h82, 8'h9F);
        rd(8'h10);
        check("tracked period", {31'h0000_0000, q >= 32'h0000_0004 && q <= 32'h0000_000B}, 32'h0000_0001);
        @(posedge clk);
        valid <= 1'b0;
        poll(8'h04, 8'h1F);
        @(posedge clk);
        valid <= 1'b1;
        poll(8'h02, 8'h1F);
        wb(1'b1, 8'h00, 4'hF, 32'h0000_0009);
        rd(8'h0C);
        check("lra brake", q & 32'h0000_001F, 32'h0000_0010);
        @(posedge clk);
        valid <= 1'b0;
        poll(8'h01, 8'h1F);
    endtask
    task automatic lra_fixed();
        int n;
        @(posedge clk);
        moving <= 1'b0;
        valid <= 1'b1;
        wb(1'b1, 8'h00, 4'hF, 32'h0000_0007);
        poll(8'h08, 8'h1F);
        @(posedge clk);
        moving <= 1'b1;
        wait_side(1'b1, 10000, n);
        wait_side(1'b0, 10000, n);
        wait_side(1'b1, 10000, n);
        // One 97.56 us unit makes one half period of field 2
        check("fixed half period", 32'(n + 1), 32'h0000_130E);
        rd(8'h0C);
        check("fixed kept", q & 32'h0000_001F, 32'h0000_0008);
        wb(1'b1, 8'h00, 4'hF, 32'h0000_000B);
        rd(8'h0C);
        check("no brake", q & 32'h0000_001F, 32'h0000_0001);
        repeat (5) @(posedge clk);
        check("outputs idle", {30'h0000_0000, out_p, out_n}, 32'h0000_0000);
    endtask
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {cyc, stb, we, trig, valid, moving} = 6'h00;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0000_0000;
        n_fail = 0;
        cmp_count = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        reset_values();
        erm_start_stop();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        lra_track();
        lra_fixed();
        stop_test();
    end
endmodule // lrc_top_tb
